// ---- pkg/bsdc_pkg.sv ----
package bsdc_pkg;
  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [4:0] IDX_CFG1 = 5'h0B;
  localparam logic [4:0] IDX_CFG2 = 5'h0C;
  localparam logic [4:0] IDX_DIS = 5'h0D;
  localparam logic [4:0] IDX_DIAG = 5'h0E;
  localparam logic [4:0] IDX_STAT = 5'h0F;
  localparam logic [4:0] IDX_TON = 5'h10;
  localparam logic [4:0] IDX_PER = 5'h11;
  // field positions
  localparam int B_FAST_SS = 0;
  localparam int B_PSEN = 1;
  localparam int B_DIM_EXT = 2;
  localparam int B_START = 3;
  localparam int B_SMASK = 2;
  localparam int B_OMASK = 3;
  localparam int B_PUMP_DIS = 6;
  localparam int B_BSTOV = 24;
  localparam int B_RT = 25;
  localparam int B_CURRENT_REFERENCE_PIN = 26;
  localparam int B_GND = 27;
  // reset values
  localparam logic [31:0] RST_CFG1 = 32'h0000_0004;
  localparam logic [31:0] RST_TON = 32'h0000_0100;
  localparam logic [31:0] RST_PER = 32'h0000_1000;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 50;
  localparam int T_PUMP_US = 2000;
  localparam int T_SS_SLOW_US = 50000;
  localparam int T_SS_FAST_US = 22000;
  localparam int T_FULL_US = 10000;
  localparam int T_LD_ENTER_NS = 50000;
  localparam int T_LD_EXIT_NS = 51000;
  localparam int LD_ENTER_CYC = T_LD_ENTER_NS * CLK_MHZ / 1000;
  localparam int LD_EXIT_CYC = T_LD_EXIT_NS * CLK_MHZ / 1000;
  // 20 MHz sample tick from 50 MHz: two ticks per five cycles
  localparam logic [2:0] TICK_ADD = 3'h2;
  localparam logic [2:0] TICK_MOD = 3'h5;
  // dac codes: lsb about 1.95 mV, step 5 lsb stays under 10 mV
  localparam logic [8:0] DAC_STEP = 9'h005;
  localparam logic [8:0] DAC_MIN = 9'h0F7;
  localparam logic [8:0] DAC_MAX = 9'h1FE;
  localparam int SS_STEP_CYC = 1000;
  localparam int CHECK_CYC = 16;
  typedef enum logic [2:0] {
    ST_IDLE, ST_PUMP, ST_CHECK, ST_BLOCK, ST_SOFT, ST_WAIT, ST_RUN
  } bsdc_state_t;
endpackage

// ---- core/bsdc_ctrl.sv ----
`timescale 1ns/1ps
// Overview of operation
// - after bias done and supplies good, pump gate, wait 2 ms.
// - with check source on and boost switch off, run unused, ground-short, timing and reference checks.
// - any used sink shorted to ground keeps the boost from starting.
// - unused channels disabled before soft-start; pin-detected ones never flag faults, register-disabled ones still flag ground shorts.
// - stage two steps dac up until feedback reaches slow or fast target.
// - stage two lasts 50 ms, or 22 ms in fast startup.
// - fast startup chosen by fast soft-start bit in config one.
// - stage three needs stage two done and dimming high, then seeks window.
// - stage three dac updates on dimming rise, or each 10 ms at full duty.
// - each dac update moves at most 10 mV.
// - unused sinks disconnected before soft-start so open and short faults stay quiet.
// - on overvoltage after soft-start, low sinks leave the minimum detector.
// - open string drives fault low and sets that channel's bit.
// - overvoltage without open string pauses switching until hysteresis, sets bit.
// - short checked at sink falling edge against selected threshold.
// - shorted strings disconnected, fault held until a dimming rise sees removal.
// - short check off in low-dimming, continuous with dimming held high.
// - load dump withholds short flag until minimum string falls below level.
// - brightness from dimming pin or on-time registers, sampled at 20 MHz in phase-shift mode.
// - enter low-dimming below 50 us on-time, leave above 51 us.
// - phase-shift bit spreads strings evenly, recomputed when strings drop.
// - without phase shift all sinks switch together.
module bsdc_ctrl #(
  parameter int NCH = 6,
  parameter int PW = 20,
  parameter int PUMP_CYC = bsdc_pkg::T_PUMP_US * bsdc_pkg::CLK_MHZ,
  parameter int SS_SLOW_CYC = bsdc_pkg::T_SS_SLOW_US * bsdc_pkg::CLK_MHZ,
  parameter int SS_FAST_CYC = bsdc_pkg::T_SS_FAST_US * bsdc_pkg::CLK_MHZ,
  parameter int FULL_CYC = bsdc_pkg::T_FULL_US * bsdc_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // supervisors and analog comparators (asynchronous)
  input wire logic BIAS_DONE_I,
  input wire logic SUPPLY_OK_I,
  input wire logic DIM_I,
  input wire logic FB_TARGET_I,
  input wire logic OVP_I,
  input wire logic OVP_CLEAR_I,
  input wire logic MIN_BELOW_LD_I,
  input wire logic RT_FAULT_I,
  input wire logic CURRENT_REFERENCE_PIN_FAULT_I,
  input wire logic [NCH-1:0] OUT_GND_I,
  input wire logic [NCH-1:0] OUT_UNUSED_I,
  input wire logic [NCH-1:0] OUT_LOW_I,
  input wire logic [NCH-1:0] OUT_HIGH_I,
  input wire logic [NCH-1:0] OUT_OPEN_I,
  input wire logic [NCH-1:0] OUT_SHORT_I,
  // power stage and sinks
  output logic GATE_PUMP_EN_O,
  output logic CHECK_SRC_EN_O,
  output logic BOOST_SW_EN_O,
  output logic FAST_TARGET_O,
  output logic [1:0] SHORT_SEL_O,
  output logic [8:0] DAC_O,
  output logic [NCH-1:0] SINK_EN_O,
  output logic [NCH-1:0] MIN_DET_EN_O,
  // open-drain fault pin
  output logic FAULT_N_O,
  output logic FAULT_OE_O
);
  localparam int NS = 9 + 6 * NCH;
  localparam int TW = 24;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [NS-1:0] raw, s1_q, s2_q;
  assign raw = {BIAS_DONE_I, SUPPLY_OK_I, DIM_I, FB_TARGET_I, OVP_I, OVP_CLEAR_I,
                MIN_BELOW_LD_I, RT_FAULT_I, CURRENT_REFERENCE_PIN_FAULT_I, OUT_GND_I, OUT_UNUSED_I,
                OUT_LOW_I, OUT_HIGH_I, OUT_OPEN_I, OUT_SHORT_I};
  // second stage is the only reader of the first
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic bias_ok, sup_ok, dim_s, fb_hit, ovp, ovp_clr, min_ld, rt_f, current_reference_pin_f;
  logic [NCH-1:0] gnd, unus, low, high, open_c, shrt;
  assign {bias_ok, sup_ok, dim_s, fb_hit, ovp, ovp_clr, min_ld, rt_f, current_reference_pin_f, gnd,
          unus, low, high, open_c, shrt} = s2_q;

  // ****************************************
  // register bus
  // ****************************************
  logic [31:0] cfg1_q, cfg2_q, dis_q, ton_q, per_q, diag_q, rdat_q, stat;
  logic wr_q;
  logic [4:0] widx_q;
  logic [4:0] aidx;
  logic take;
  assign take = HSEL_I & HREADY_I & HTRANS_I[1];
  assign aidx = HADDR_I[6:2];
  assign HREADYOUT_O = 1'b1; // zero wait states, answer always okay
  assign HRESP_O = 1'b0;
  assign HRDATA_O = rdat_q;
  // address phase latch and read data prefetch
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_q <= 1'b0;
      widx_q <= '0;
      rdat_q <= '0;
    end else begin
      wr_q <= take & HWRITE_I;
      widx_q <= aidx;
      if (take && !HWRITE_I) begin
        unique case (aidx)
          bsdc_pkg::IDX_CFG1: rdat_q <= cfg1_q;
          bsdc_pkg::IDX_CFG2: rdat_q <= cfg2_q;
          bsdc_pkg::IDX_DIS: rdat_q <= dis_q;
          bsdc_pkg::IDX_DIAG: rdat_q <= diag_q;
          bsdc_pkg::IDX_STAT: rdat_q <= stat;
          bsdc_pkg::IDX_TON: rdat_q <= ton_q;
          bsdc_pkg::IDX_PER: rdat_q <= per_q;
          default: rdat_q <= '0;
        endcase
      end
    end
  end
  // control registers written in the data phase
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg1_q <= bsdc_pkg::RST_CFG1;
      cfg2_q <= '0;
      dis_q <= '0;
      ton_q <= bsdc_pkg::RST_TON;
      per_q <= bsdc_pkg::RST_PER;
    end else if (wr_q) begin
      if (widx_q == bsdc_pkg::IDX_CFG1) cfg1_q <= HWDATA_I;
      if (widx_q == bsdc_pkg::IDX_CFG2) cfg2_q <= HWDATA_I;
      if (widx_q == bsdc_pkg::IDX_DIS) dis_q <= HWDATA_I;
      if (widx_q == bsdc_pkg::IDX_TON) ton_q <= HWDATA_I;
      if (widx_q == bsdc_pkg::IDX_PER) per_q <= HWDATA_I;
    end
  end
  logic fast, psen, dim_ext;
  assign fast = cfg1_q[bsdc_pkg::B_FAST_SS];
  assign psen = cfg1_q[bsdc_pkg::B_PSEN];
  assign dim_ext = cfg1_q[bsdc_pkg::B_DIM_EXT];
  assign FAST_TARGET_O = fast;
  assign SHORT_SEL_O = cfg2_q[1:0];

  // ****************************************
  // dimming reference and low-dimming mode
  // ****************************************
  logic [15:0] icnt_q;
  logic int_pwm, ref_q, ref_rise, ref_fall, full, low_dim_q;
  logic [12:0] hcnt_q;
  logic [TW-1:0] fcnt_q;
  // internal pwm from on-time registers when the pin is not used
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) icnt_q <= '0;
    else icnt_q <= (icnt_q >= per_q[15:0] - 16'h0001) ? '0 : icnt_q + 16'h0001;
  end
  assign int_pwm = icnt_q < ton_q[15:0];
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) ref_q <= 1'b0;
    else ref_q <= dim_ext ? dim_s : int_pwm;
  end
  assign ref_rise = (dim_ext ? dim_s : int_pwm) & ~ref_q;
  assign ref_fall = ~(dim_ext ? dim_s : int_pwm) & ref_q;
  // on-time length and full-duty detection share the high counters
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hcnt_q <= '0;
      fcnt_q <= '0;
      low_dim_q <= 1'b0;
    end else begin
      hcnt_q <= !ref_q ? '0 : (&hcnt_q ? hcnt_q : hcnt_q + 13'h0001);
      fcnt_q <= (!ref_q || fcnt_q >= TW'(FULL_CYC - 1)) ? '0 : fcnt_q + TW'(1);
      if (ref_fall && hcnt_q < 13'(bsdc_pkg::LD_ENTER_CYC)) low_dim_q <= 1'b1;
      else if (ref_fall && hcnt_q > 13'(bsdc_pkg::LD_EXIT_CYC)) low_dim_q <= 1'b0;
    end
  end
  assign full = ref_q & (&hcnt_q); // held high long past any pulse

  // ****************************************
  // startup sequencer
  // ****************************************
  bsdc_pkg::bsdc_state_t st_q;
  logic [TW-1:0] tmr_q;
  logic [NCH-1:0] unused_q, gnd_q, open_q, short_q, active;
  logic rt_q, current_reference_pin_q;
  logic [8:0] dac_q;
  logic ss_done, pump_done, chk_done, step_tick;
  assign pump_done = tmr_q >= TW'(PUMP_CYC - 1);
  assign chk_done = tmr_q >= TW'(bsdc_pkg::CHECK_CYC - 1);
  assign ss_done = tmr_q >= (fast ? TW'(SS_FAST_CYC - 1) : TW'(SS_SLOW_CYC - 1));
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q <= bsdc_pkg::ST_IDLE;
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + TW'(1);
      if (!sup_ok || !cfg1_q[bsdc_pkg::B_START]) begin
        st_q <= bsdc_pkg::ST_IDLE;
        tmr_q <= '0;
      end else begin
        unique case (st_q)
          bsdc_pkg::ST_IDLE: if (bias_ok) begin
            st_q <= bsdc_pkg::ST_PUMP;
            tmr_q <= '0;
          end
          bsdc_pkg::ST_PUMP: if (pump_done) begin
            st_q <= bsdc_pkg::ST_CHECK;
            tmr_q <= '0;
          end
          bsdc_pkg::ST_CHECK: if (chk_done) begin
            // ground short or resistor fault keeps the converter off
            st_q <= (|(gnd & ~unus) || rt_f || current_reference_pin_f) ?
                    bsdc_pkg::ST_BLOCK : bsdc_pkg::ST_SOFT;
            tmr_q <= '0;
          end
          bsdc_pkg::ST_BLOCK: tmr_q <= '0;
          bsdc_pkg::ST_SOFT: if (ss_done) st_q <= bsdc_pkg::ST_WAIT;
          bsdc_pkg::ST_WAIT: if (ref_q) st_q <= bsdc_pkg::ST_RUN;
          bsdc_pkg::ST_RUN: tmr_q <= '0;
        endcase
      end
    end
  end
  assign GATE_PUMP_EN_O = (st_q != bsdc_pkg::ST_IDLE) & ~dis_q[bsdc_pkg::B_PUMP_DIS];
  assign CHECK_SRC_EN_O = st_q == bsdc_pkg::ST_CHECK;
  // power-up check results, caught at the end of the check window
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      unused_q <= '0;
      gnd_q <= '0;
      rt_q <= 1'b0;
      current_reference_pin_q <= 1'b0;
    end else if (st_q == bsdc_pkg::ST_CHECK && chk_done) begin
      unused_q <= unus | dis_q[NCH-1:0];
      gnd_q <= gnd & ~unus;
      rt_q <= rt_f;
      current_reference_pin_q <= current_reference_pin_f;
    end
  end
  assign active = ~unused_q & ~open_q & ~short_q;

  // ****************************************
  // dac reference: soft-start and headroom search
  // ****************************************
  logic [9:0] scnt_q;
  logic upd, go_up, go_dn;
  assign step_tick = scnt_q == 10'(bsdc_pkg::SS_STEP_CYC - 1);
  assign upd = (st_q == bsdc_pkg::ST_RUN) &
               (full ? fcnt_q == TW'(FULL_CYC - 1) : ref_rise);
  assign go_up = |(low & active & ~open_q);
  assign go_dn = (active != '0) && ((high & active) == active);
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) scnt_q <= '0;
    else scnt_q <= step_tick ? '0 : scnt_q + 10'h001;
  end
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) dac_q <= '0;
    else if (st_q == bsdc_pkg::ST_IDLE) dac_q <= '0;
    else if (st_q == bsdc_pkg::ST_SOFT && step_tick && !fb_hit)
      dac_q <= (dac_q > bsdc_pkg::DAC_MAX - bsdc_pkg::DAC_STEP) ?
               bsdc_pkg::DAC_MAX : dac_q + bsdc_pkg::DAC_STEP;
    else if (upd && go_up)
      dac_q <= (dac_q > bsdc_pkg::DAC_MAX - bsdc_pkg::DAC_STEP) ?
               bsdc_pkg::DAC_MAX : dac_q + bsdc_pkg::DAC_STEP;
    // below the floor a down step holds instead of jumping up to it
    else if (upd && go_dn && dac_q > bsdc_pkg::DAC_MIN)
      dac_q <= (dac_q < bsdc_pkg::DAC_MIN + bsdc_pkg::DAC_STEP) ?
               bsdc_pkg::DAC_MIN : dac_q - bsdc_pkg::DAC_STEP;
  end
  assign DAC_O = dac_q;

  // ****************************************
  // open strings, overvoltage, shorts, load dump
  // ****************************************
  logic ovh_q, bstov_q, ld_q, after_ss;
  logic [NCH-1:0] sink_q, sink_d, sl_chk, ovp_open;
  assign after_ss = (st_q == bsdc_pkg::ST_WAIT) | (st_q == bsdc_pkg::ST_RUN);
  assign ovp_open = open_c & ~unused_q;
  // short sampled on sink fall, or all the time at full duty
  assign sl_chk = (sink_q & ~sink_d) | (full ? sink_q : '0);
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      open_q <= '0;
      short_q <= '0;
      ovh_q <= 1'b0;
      ld_q <= 1'b0;
    end else if (st_q == bsdc_pkg::ST_IDLE) begin
      open_q <= '0;
      short_q <= '0;
      ovh_q <= 1'b0;
      ld_q <= 1'b0;
    end else begin
      if (after_ss && ovp) open_q <= open_q | ovp_open;
      // pause switching until feedback drops by the hysteresis
      if (after_ss && ovp && ovp_open == '0) ovh_q <= 1'b1;
      else if (ovp_clr) ovh_q <= 1'b0;
      if (go_dn_ld(shrt, active)) ld_q <= 1'b1;
      else if (min_ld) ld_q <= 1'b0;
      for (int k = 0; k < NCH; k++) begin
        if (sl_chk[k] && shrt[k] && !low_dim_q && !go_dn_ld(shrt, active))
          short_q[k] <= 1'b1;
        else if (ref_rise && !shrt[k] && !full)
          short_q[k] <= 1'b0;
      end
    end
  end
  // load dump: every active string above the short threshold
  function automatic logic go_dn_ld(input logic [NCH-1:0] s, input logic [NCH-1:0] a);
    go_dn_ld = (a != '0) && ((s & a) == a);
  endfunction
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) bstov_q <= 1'b0;
    else if (after_ss && ovp && ovp_open == '0) bstov_q <= 1'b1; // set beats clear
    else if (wr_q && widx_q == bsdc_pkg::IDX_DIAG && HWDATA_I[bsdc_pkg::B_BSTOV])
      bstov_q <= 1'b0;
  end
  assign diag_q = {4'h0, |gnd_q, current_reference_pin_q, rt_q, bstov_q, 2'h0, short_q,
                   2'h0, gnd_q, 2'h0, open_q};
  assign MIN_DET_EN_O = ~unused_q & ~open_q & ~short_q;
  assign BOOST_SW_EN_O = ~ovh_q & ((st_q == bsdc_pkg::ST_SOFT) |
                         ((st_q == bsdc_pkg::ST_WAIT) | (st_q == bsdc_pkg::ST_RUN)) &
                         (low_dim_q | ref_q));

  // ****************************************
  // phase-shift generator on the 20 MHz sample tick
  // ****************************************
  logic [2:0] acc_q;
  logic tick, sref_q;
  logic [PW-1:0] ph_q, plen_q, on_q, step;
  logic [2:0] nact;
  logic [2:0] pos [NCH];
  logic [NCH-1:0] ps_on;
  assign tick = acc_q >= bsdc_pkg::TICK_MOD - bsdc_pkg::TICK_ADD;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      acc_q <= '0;
      sref_q <= 1'b0;
      ph_q <= '0;
      plen_q <= '0;
      on_q <= '0;
    end else begin
      acc_q <= tick ? acc_q + bsdc_pkg::TICK_ADD - bsdc_pkg::TICK_MOD
                    : acc_q + bsdc_pkg::TICK_ADD;
      if (tick) begin
        sref_q <= ref_q;
        ph_q <= (ref_q && !sref_q) ? '0 : (&ph_q ? ph_q : ph_q + PW'(1));
        if (ref_q && !sref_q) plen_q <= ph_q + PW'(1);
        if (!ref_q && sref_q) on_q <= ph_q;
      end
    end
  end
  // slot of each string among those still active
  always_comb begin
    nact = '0;
    for (int k = 0; k < NCH; k++) begin
      pos[k] = nact;
      nact = nact + 3'(active[k]);
    end
  end
  assign step = (nact == '0) ? '0 : plen_q / PW'(nact);
  for (genvar k = 0; k < NCH; k++) begin : g_ch
    logic [PW-1:0] off, rel;
    assign off = PW'(step * PW'(pos[k]));
    assign rel = (ph_q >= off) ? ph_q - off : ph_q + plen_q - off;
    assign ps_on[k] = full | (rel < on_q);
  end
  // without phase shift every sink follows the reference together
  assign sink_d = (st_q == bsdc_pkg::ST_RUN) ?
                  active & (psen ? ps_on : {NCH{ref_q}}) : '0;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) sink_q <= '0;
    else sink_q <= sink_d;
  end
  assign SINK_EN_O = sink_q;

  // ****************************************
  // fault pin and status
  // ****************************************
  logic flt_q;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) flt_q <= 1'b0;
    else flt_q <= (|open_q & ~cfg2_q[bsdc_pkg::B_OMASK])
                  | (|short_q & ~ld_q & ~cfg2_q[bsdc_pkg::B_SMASK])
                  | (|gnd_q) | rt_q | current_reference_pin_q;
  end
  assign FAULT_OE_O = flt_q;
  assign FAULT_N_O = 1'b0;
  assign stat = {2'h0, active, 2'h0, ld_q, low_dim_q, 3'h0, dac_q, 5'h00, st_q};

  // ****************************************
  // checks
  // ****************************************
  sequence s_fall_short(int k);
    sink_q[k] && !sink_d[k] && shrt[k] && !low_dim_q && !go_dn_ld(shrt, active)
      && st_q != bsdc_pkg::ST_IDLE;
  endsequence
  property p_block_off;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    st_q == bsdc_pkg::ST_BLOCK |-> !BOOST_SW_EN_O && SINK_EN_O == '0;
  endproperty
  a_block_off: assert property (p_block_off) else $error("boost on while blocked");
  property p_dac_step;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    st_q != bsdc_pkg::ST_IDLE |=> (dac_q - $past(dac_q) <= 9'h005) ||
                                 ($past(dac_q) - dac_q <= 9'h005);
  endproperty
  a_dac_step: assert property (p_dac_step) else $error("dac step too large");
  property p_unused_dark;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (SINK_EN_O & unused_q) == '0 && (MIN_DET_EN_O & unused_q) == '0;
  endproperty
  a_unused_dark: assert property (p_unused_dark) else $error("unused sink live");
  property p_soft_len;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    st_q == bsdc_pkg::ST_SOFT && $past(st_q) == bsdc_pkg::ST_SOFT ##1
      st_q == bsdc_pkg::ST_WAIT |-> $past(ss_done);
  endproperty
  a_soft_len: assert property (p_soft_len) else $error("soft-start ended early");
  property p_target_hold;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    st_q == bsdc_pkg::ST_SOFT && fb_hit ##1 st_q == bsdc_pkg::ST_SOFT
      |-> dac_q == $past(dac_q);
  endproperty
  a_target_hold: assert property (p_target_hold) else $error("dac rose past target");
  property p_ovp_pause;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    after_ss && ovp && ovp_open == '0 && cfg1_q[bsdc_pkg::B_START] && sup_ok
      |=> bstov_q && !BOOST_SW_EN_O;
  endproperty
  a_ovp_pause: assert property (p_ovp_pause) else $error("no pause on overvoltage");
  property p_short_seen;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    s_fall_short(2) ##0 cfg1_q[bsdc_pkg::B_START] && sup_ok |=> short_q[2];
  endproperty
  a_short_seen: assert property (p_short_seen) else $error("short not caught");
  property p_ld_quiet;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    ld_q && open_q == '0 && gnd_q == '0 && !rt_q && !current_reference_pin_q |=> !FAULT_OE_O;
  endproperty
  a_ld_quiet: assert property (p_ld_quiet) else $error("fault during load dump");
  property p_open_flag;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    open_q != '0 && !cfg2_q[bsdc_pkg::B_OMASK] |=> FAULT_OE_O;
  endproperty
  a_open_flag: assert property (p_open_flag) else $error("open not flagged");
endmodule

// ---- bench/bsdc_strings.sv ----
`timescale 1ns/1ps
// ****************************************
// led strings and boost stage model
// ****************************************
module bsdc_strings (
  // clock
  input wire logic clk_i,
  // design side
  input wire logic boost_i,
  input wire logic [5:0] sink_i,
  // scenario knobs
  input wire logic [5:0] open_i,
  input wire logic up_i,
  // comparators
  output logic fb_o,
  output logic ovp_o,
  output logic clr_o,
  output logic [5:0] open_o,
  output logic [5:0] low_o,
  output logic [5:0] high_o
);
  logic [7:0] ramp_q = 8'h00;
  // output climbs only while switching, so feedback lags the enable
  always_ff @(posedge clk_i) begin
    if (!boost_i) ramp_q <= 8'h00;
    else if (ramp_q != 8'hFF) ramp_q <= ramp_q + 8'h01;
  end
  // open string, or a long unbroken run, drives the boost to overvoltage
  assign fb_o = ramp_q > 8'h40;
  assign ovp_o = boost_i && ((|(open_i & sink_i)) || ramp_q == 8'hFF);
  assign clr_o = !ovp_o;
  assign open_o = open_i & sink_i;
  assign low_o = up_i ? ~open_i : 6'h00;
  assign high_o = up_i ? 6'h00 : ~open_i;
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [4:0] idx; logic [31:0] rst; logic [31:0] wd; logic [31:0] back;} bsdc_row_t;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, dim = 1'b0, bias = 1'b0, sup = 1'b0, up = 1'b1;
  logic rtf = 1'b0, current_reference_pin = 1'b0, hready, hresp, pump, chk, boost, fast, fb, ovp, clr, foe, fn;
  logic [1:0] trans = 2'h0, ssel;
  logic [31:0] addr = 32'h0, wdat = 32'h0, rdat, v;
  logic [5:0] gnd = 6'h00, unu = 6'h00, opn = 6'h00, open_s, low, high, sink, mdet;
  logic [8:0] dac, d;
  logic [5:0] sht = 6'h00;
  logic ldrel = 1'b1;
  int miscompares = 0, cmp_count = 0, n;
  bsdc_row_t rows[6] = '{'{5'h0B, 32'h4, 32'h4, 32'h4}, '{5'h0C, 32'h0, 32'h3, 32'h3},
    '{5'h10, 32'h100, 32'h200, 32'h200}, '{5'h11, 32'h1000, 32'h800, 32'h800},
    '{5'h0E, 32'h0, 32'h0, 32'h0}, '{5'h1F, 32'h0, 32'hFFFFFFFF, 32'h0}};
  bsdc_ctrl #(.PUMP_CYC(50), .SS_SLOW_CYC(400), .SS_FAST_CYC(200), .FULL_CYC(300)) dut (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(1'b1), .HADDR_I(addr), .HTRANS_I(trans),
    .HWRITE_I(wr), .HSIZE_I(3'h2), .HWDATA_I(wdat), .HREADY_I(hready), .HRDATA_O(rdat),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .BIAS_DONE_I(bias), .SUPPLY_OK_I(sup), .DIM_I(dim),
    .FB_TARGET_I(fb), .OVP_I(ovp), .OVP_CLEAR_I(clr), .MIN_BELOW_LD_I(ldrel), .RT_FAULT_I(rtf),
    .CURRENT_REFERENCE_PIN_FAULT_I(current_reference_pin), .OUT_GND_I(gnd), .OUT_UNUSED_I(unu), .OUT_LOW_I(low),
    .OUT_HIGH_I(high), .OUT_OPEN_I(open_s), .OUT_SHORT_I(sht), .GATE_PUMP_EN_O(pump),
    .CHECK_SRC_EN_O(chk), .BOOST_SW_EN_O(boost), .FAST_TARGET_O(fast), .SHORT_SEL_O(ssel),
    .DAC_O(dac), .SINK_EN_O(sink), .MIN_DET_EN_O(mdet), .FAULT_N_O(fn), .FAULT_OE_O(foe));
  bsdc_strings far (.clk_i(clk), .boost_i(boost), .sink_i(sink), .open_i(opn), .up_i(up),
    .fb_o(fb), .ovp_o(ovp), .clr_o(clr), .open_o(open_s), .low_o(low), .high_o(high));
  // ****************************************
  // clock, bus and checking helpers
  // ****************************************
  initial begin
    forever #10 clk = ~clk;
  end
  // single word transfer, called just after a rising edge
  task automatic bus(input logic w, input logic [4:0] idx, input logic [31:0] wd);
    trans <= 2'h2; wr <= w; addr <= {25'h0, idx, 2'h0};
    do @(posedge clk); while (hready !== 1'b1);
    trans <= 2'h0; wdat <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    v = rdat;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // polls the state field; bounded so a stuck sequence cannot hang
  task automatic wait_st(input logic [2:0] s);
    n = 0;
    do begin bus(1'b0, 5'h0F, 32'h0); n++; end while (v[2:0] !== s && n < 400);
    check("state", {29'h0, v[2:0]}, {29'h0, s});
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1; bias <= 1'b1; sup <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      bus(1'b0, rows[i].idx, 32'h0);
      check("reset value", v, rows[i].rst);
      bus(1'b1, rows[i].idx, rows[i].wd);
      bus(1'b0, rows[i].idx, 32'h0);
      check("read back", v, rows[i].back);
    end
    check("short select", {30'h0, ssel}, 32'h3);
    // each power-up check failure must block the boost
    for (int k = 0; k < 3; k++) begin
      gnd <= (k == 0) ? 6'h01 : 6'h00; rtf <= (k == 1); current_reference_pin <= (k == 2);
      bus(1'b1, 5'h0B, 32'hC);
      n = 0;
      while (chk !== 1'b1 && n < 300) begin @(posedge clk); n++; end
      check("pump wait", {31'h0, n >= 50}, 32'h1);
      check("pump on", {31'h0, pump}, 32'h1);
      wait_st(3'h3);
      check("boost off", {31'h0, boost}, 32'h0);
      bus(1'b0, 5'h0E, 32'h0);
      check("diag bit", {31'h0, v[(k == 0) ? 27 : 24 + k]}, 32'h1);
      check("fault pin", {31'h0, foe}, 32'h1);
      bus(1'b1, 5'h0B, 32'h4);
    end
    gnd <= 6'h00; rtf <= 1'b0; current_reference_pin <= 1'b0; unu <= 6'h20;
    bus(1'b1, 5'h0B, 32'hD);
    wait_st(3'h5);
    check("fast target", {31'h0, fast}, 32'h1);
    dim <= 1'b1;
    wait_st(3'h6);
    check("unused sink", {31'h0, sink[5]}, 32'h0);
    check("no fault", {31'h0, foe}, 32'h0);
    // climb well clear of the lower clamp first
    repeat (54) begin
      dim <= 1'b0;
      repeat (4) @(posedge clk);
      dim <= 1'b1;
      repeat (4) @(posedge clk);
    end
    // dac follows window comparators one step per dimming rise
    for (int k = 0; k < 4; k++) begin
      up <= (k < 2);
      repeat (30) @(posedge clk);
      d = dac;
      dim <= 1'b0;
      repeat (20) @(posedge clk);
      dim <= 1'b1;
      repeat (10) @(posedge clk);
      check("dac step", {23'h0, dac}, {23'h0, (k < 2) ? d + 9'h005 : d - 9'h005});
    end
    // short ignored in low-dimming, caught at the fall of a long pulse
    sht <= 6'h04;
    dim <= 1'b0;
    repeat (20) @(posedge clk);
    check("short in low-dim", {31'h0, foe}, 32'h0);
    dim <= 1'b1;
    repeat (2700) @(posedge clk);
    dim <= 1'b0;
    repeat (20) @(posedge clk);
    check("short fault", {31'h0, foe}, 32'h1);
    dim <= 1'b1;
    repeat (20) @(posedge clk);
    check("short sink off", {26'h0, sink}, 32'h1B);
    // all live strings high is a load dump: flag withheld until release
    sht <= 6'h1F;
    ldrel <= 1'b0;
    repeat (20) @(posedge clk);
    check("load dump quiet", {31'h0, foe}, 32'h0);
    sht <= 6'h04;
    ldrel <= 1'b1;
    repeat (20) @(posedge clk);
    check("load dump over", {31'h0, foe}, 32'h1);
    sht <= 6'h00;
    dim <= 1'b0;
    repeat (20) @(posedge clk);
    dim <= 1'b1;
    repeat (20) @(posedge clk);
    check("short removed", {31'h0, foe}, 32'h0);
    opn <= 6'h02;
    repeat (20) @(posedge clk);
    check("open fault", {31'h0, foe}, 32'h1);
    check("detector", {31'h0, mdet[1]}, 32'h0);
    bus(1'b0, 5'h0E, 32'h0);
    check("open bit", {26'h0, v[5:0]}, 32'h2);
    check("overvoltage bit", {31'h0, v[24]}, 32'h1);
    check("fault level", {31'h0, fn}, 32'h0);
    check("bus response", {31'h0, hresp}, 32'h0);
    print_verdict;
  end
endmodule
